//--- include/gpio_pin_defs.vh
// Constants for the general-purpose port pin block and its register slave.
// Assumes an AXI4-Lite master with 32-bit data and a 50 MHz core clock.
//
// Summary of operation
// - Writing one to input bit toggles latch.
// - Global pull-up disable turns every pull-up off.
// - Reset clears direction and latch bits.
// - Pull-up only for input, latch one, enabled.
// - Output drives the latch value, no pull-up.
// - Pin level readable in input register, except clamped pins during sleep.
// - Falling-edge latch then rising-edge input register.
// - Pin change seen after half to 1.5 periods.
// - Written value visible one period after write.
// - Sleep clamps the digital input to ground.
// - Clamp skipped where external interrupt enabled.
// - High clamped interrupt pin flags on wake.
`ifndef GPIO_PIN_DEFS_VH
`define GPIO_PIN_DEFS_VH

// ************************************************************
// Register offsets
// ************************************************************
`define OFS_INPUT 8'h00
`define OFS_LATCH 8'h04
`define OFS_DIRECTION 8'h08
`define OFS_CONTROL 8'h0C
`define OFS_IRQ_ENABLE 8'h10
`define OFS_STATUS 8'h14
`define OFS_MASK 8'h18
`define OFS_SENSE 8'h1C

// ************************************************************
// Fields and reset values
// ************************************************************
`define CTRL_PUD_BIT 0
`define CTRL_SLEEP_BIT 1
`define RST_ZERO 32'h00000000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- verilog/pin_sync.v
// Two-stage input synchroniser for a group of pins.
// Assumes a single clock; the first stage captures on the falling edge.
`timescale 1ns/1ps
module pin_sync #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    // Data
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] half_stage;

    // The first stage closes when the clock falls.
    always @(negedge core_clk)
    begin
        if (sys_rst)
            half_stage <= {WIDTH{1'b0}};
        else
            half_stage <= async_in;
    end

    // The second stage loads at the next rising edge.
    always @(posedge core_clk)
    begin
        if (sys_rst)
            sync_out <= {WIDTH{1'b0}};
        else
            sync_out <= half_stage;
    end
endmodule // pin_sync

//--- verilog/gpio_port.v
// One general-purpose port of WIDTH pins behind an AXI4-Lite slave.
// Assumes pad logic outside resolves the pin from out, oe and pull-up.
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "gpio_pin_defs.vh"
module gpio_port #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    // AXI4-Lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Pins
    input wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] pin_out,
    output wire [WIDTH-1:0] pin_oe,
    output wire [WIDTH-1:0] pin_pullup,
    // Sleep controller
    input wire sleep_clamp,
    // Interrupt
    output wire irq
);
    // ************************************************************
    // Register state
    // ************************************************************
    reg [WIDTH-1:0] output_latch_bit;
    reg [WIDTH-1:0] pin_direction_register_bit;
    reg global_pullup_disable;
    reg [WIDTH-1:0] ext_irq_enable;
    reg [WIDTH-1:0] edge_sense;
    reg [WIDTH-1:0] status;
    reg [WIDTH-1:0] mask;
    reg [WIDTH-1:0] prev_input;
    reg [7:0] aw_addr;
    reg aw_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg w_held;
    wire [WIDTH-1:0] pin_input_bit;
    wire [WIDTH-1:0] clamped_in;
    wire [WIDTH-1:0] clamp_sel;
    wire [WIDTH-1:0] change_evt;
    wire do_write;
    wire [WIDTH-1:0] wbits;
    reg [31:0] next_rdata;
    reg [1:0] next_rresp;
    reg [WIDTH-1:0] next_status;
    wire next_pud;
    wire [WIDTH-1:0] toggled_latch;

    // ************************************************************
    // Register decode
    // ************************************************************
    // Returns one for every offset that names a register.
    function reg_hit;
        input [7:0] addr;
        begin
            case (addr)
                `OFS_INPUT, `OFS_LATCH,
                `OFS_DIRECTION, `OFS_CONTROL,
                `OFS_IRQ_ENABLE, `OFS_STATUS,
                `OFS_MASK, `OFS_SENSE:
                    reg_hit = 1'b1;
                default:
                    reg_hit = 1'b0;
            endcase
        end
    endfunction

    // Keeps the written bits whose byte strobe is set, zeroes the rest.
    function [WIDTH-1:0] strobed;
        input [31:0] data;
        input [3:0] strb;
        integer k;
        begin
            strobed = {WIDTH{1'b0}};
            for (k = 0; k < WIDTH; k = k + 1)
                strobed[k] = data[k] & strb[k / 8];
        end
    endfunction

    // Replaces the strobed bytes of a register with the written data.
    function [WIDTH-1:0] merged;
        input [WIDTH-1:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer k;
        begin
            merged = old;
            for (k = 0; k < WIDTH; k = k + 1)
                if (strb[k / 8])
                    merged[k] = data[k];
        end
    endfunction

    // ************************************************************
    // Pad control
    // ************************************************************
    assign pin_oe = pin_direction_register_bit;
    assign pin_out = output_latch_bit;
    assign pin_pullup = ~pin_direction_register_bit & output_latch_bit &
        {WIDTH{~global_pullup_disable}};

    // The sleep clamp forces the input low except on enabled interrupt pins.
    assign clamp_sel = {WIDTH{sleep_clamp}} & ~ext_irq_enable;
    assign clamped_in = pin_in & ~clamp_sel;

    pin_sync #(
        .WIDTH(WIDTH)
    ) u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in(clamped_in),
        .sync_out(pin_input_bit)
    );

    // ************************************************************
    // Change events
    // ************************************************************
    // A rise or a fall on a sensing pin sets its flag, including the release of the
    // sleep clamp while the pin is high.
    assign change_evt = edge_sense & (pin_input_bit ^ prev_input);

    // ************************************************************
    // Write channel
    // ************************************************************
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    assign do_write = aw_held & w_held & ~s_axi_bvalid;
    assign wbits = strobed(w_data, w_strb);
    assign toggled_latch = output_latch_bit ^ wbits;
    assign next_pud = w_strb[0] ? w_data[`CTRL_PUD_BIT] :
        global_pullup_disable;

    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            aw_addr <= 8'h00;
            aw_held <= 1'b0;
            w_data <= `RST_ZERO;
            w_strb <= 4'h0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr <= s_axi_awaddr;
                aw_held <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_held <= 1'b1;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= reg_hit(aw_addr) ? `RESP_OKAY :
                    `RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            output_latch_bit <= {WIDTH{1'b0}};
            pin_direction_register_bit <= {WIDTH{1'b0}};
            global_pullup_disable <= 1'b0;
            ext_irq_enable <= {WIDTH{1'b0}};
            edge_sense <= {WIDTH{1'b0}};
            mask <= {WIDTH{1'b0}};
            status <= {WIDTH{1'b0}};
            prev_input <= {WIDTH{1'b0}};
        end
        else
        begin
            prev_input <= pin_input_bit;
            status <= next_status;
            if (do_write)
            begin
                case (aw_addr)
                    `OFS_INPUT:
                        output_latch_bit <= toggled_latch;
                    `OFS_LATCH:
                        output_latch_bit <= merged(output_latch_bit, w_data,
                            w_strb);
                    `OFS_DIRECTION:
                        pin_direction_register_bit <= merged(
                            pin_direction_register_bit, w_data, w_strb);
                    `OFS_CONTROL:
                        global_pullup_disable <= next_pud;
                    `OFS_IRQ_ENABLE:
                        ext_irq_enable <= merged(ext_irq_enable, w_data,
                            w_strb);
                    `OFS_MASK:
                        mask <= merged(mask, w_data, w_strb);
                    `OFS_SENSE:
                        edge_sense <= merged(edge_sense, w_data, w_strb);
                    default:
                        ;
                endcase
            end
        end
    end

    // ************************************************************
    // Status flags
    // ************************************************************
    // A new event wins over a clear in the same cycle.
    always @*
    begin
        next_status = status;
        if (do_write && aw_addr == `OFS_STATUS)
            next_status = status & ~wbits;
        next_status = next_status | change_evt;
    end

    assign irq = |(status & mask);

    // ************************************************************
    // Read channel
    // ************************************************************
    assign s_axi_arready = ~s_axi_rvalid;

    always @*
    begin
        next_rdata = `RST_ZERO;
        next_rresp = reg_hit(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        case (s_axi_araddr)
            `OFS_INPUT:
                next_rdata[WIDTH-1:0] = pin_input_bit;
            `OFS_LATCH:
                next_rdata[WIDTH-1:0] = output_latch_bit;
            `OFS_DIRECTION:
                next_rdata[WIDTH-1:0] = pin_direction_register_bit;
            `OFS_CONTROL:
            begin
                next_rdata[`CTRL_PUD_BIT] = global_pullup_disable;
                next_rdata[`CTRL_SLEEP_BIT] = sleep_clamp;
            end
            `OFS_IRQ_ENABLE:
                next_rdata[WIDTH-1:0] = ext_irq_enable;
            `OFS_STATUS:
                next_rdata[WIDTH-1:0] = status;
            `OFS_MASK:
                next_rdata[WIDTH-1:0] = mask;
            `OFS_SENSE:
                next_rdata[WIDTH-1:0] = edge_sense;
            default:
                ;
        endcase
    end

    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `RST_ZERO;
            s_axi_rresp <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule // gpio_port

//--- bench/pin_ext.sv
// Pad and external circuit model for the port pins.
// Assumes the block drives out/oe/pull-up and reads the pad level back.
`timescale 1ns/1ps
module pin_ext (
    // Clock
    input wire core_clk,
    // Pad controls from the block
    input wire [7:0] pin_out,
    input wire [7:0] pin_oe,
    input wire [7:0] pin_pullup,
    // External source
    input wire [7:0] ext_en,
    input wire [7:0] ext_val,
    // Pad level
    output logic [7:0] pin_in
);
    // **********************************
    // Pad resolution
    // **********************************
    logic [7:0] flt = 8'h00;
    // An undriven pin without pull-up wanders every cycle.
    always @(posedge core_clk)
        flt <= ~flt;
    assign pin_in = pin_oe & pin_out | ~pin_oe & (ext_en & ext_val
        | ~ext_en & (pin_pullup | flt));
endmodule // pin_ext

//--- bench/gpio_port_chk.sv
// Assertion checker on the port block's top-level ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module gpio_port_chk #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    // Bus handshakes
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // Pins and interrupt
    input wire [WIDTH-1:0] pin_out,
    input wire [WIDTH-1:0] pin_oe,
    input wire [WIDTH-1:0] pin_pullup,
    input wire irq
);
    // **********************************
    // Properties
    // **********************************
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    a_reset_clear: assert property (disable iff (1'b0)
        sys_rst |=> !pin_oe && !pin_out && !pin_pullup && !irq)
        else $error("Pins not idle after reset.");
    a_pullup_gate: assert property (
        (pin_pullup & (pin_oe | ~pin_out)) == 0)
        else $error("Pull-up on a driven or low-latch pin.");
    a_latch_by_write: assert property (
        !$past(sys_rst) && $changed(pin_out) |-> $rose(s_axi_bvalid))
        else $error("Latch changed without a write.");
    a_dir_by_write: assert property (
        !$past(sys_rst) && $changed(pin_oe) |-> $rose(s_axi_bvalid))
        else $error("Direction changed without a write.");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("Write response late.");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read data late.");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped.");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data dropped.");
endmodule // gpio_port_chk

bind gpio_port gpio_port_chk #(.WIDTH(WIDTH)) i_gpio_port_chk (.*);

//--- bench/tb.sv
// Self-checking bench for the port block with a pad model.
// Assumes an 8-pin port, a 50 MHz clock and the register offsets header.
`timescale 1ns/1ps
`include "gpio_pin_defs.vh"
module tb;
    logic core_clk, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic sys_rst = 1'b1, sleep_clamp = 1'b0, s_axi_arready, s_axi_rvalid;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [7:0] ext_en = 8'hFF, ext_val = 8'h00, d, l, e, t;
    logic [7:0] pin_in, pin_out, pin_oe, pin_pullup;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, v;
    logic [31:0] seed = 32'h0000E688;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    gpio_port #(.WIDTH(8)) i_gpio_port (.*);
    pin_ext i_pin_ext (.*);
    // **********************************
    // Helpers
    // **********************************
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic logic [7:0] exp_in(logic [7:0] dd, logic [7:0] ll,
        logic [7:0] ee);
        return dd & ll | ~dd & ee;
    endfunction
    task automatic chk(string nm, logic [31:0] s, logic [31:0] x);
        tests_run++;
        if (s !== x)
        begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d.", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] x);
        logic ta, tw, tk;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= x;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        tk = 1'b0;
        while (!tk)
        begin
            @(negedge core_clk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tk = s_axi_bvalid & s_axi_bready;
            r = s_axi_bresp;
            @(posedge core_clk);
            if (ta)
                s_axi_awvalid <= 1'b0;
            if (tw)
                s_axi_wvalid <= 1'b0;
            if (tk)
                s_axi_bready <= 1'b0;
        end
    endtask
    task automatic rchk(string nm, logic [7:0] a, logic [31:0] x);
        logic ta, tk;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        tk = 1'b0;
        while (!tk)
        begin
            @(negedge core_clk);
            ta = s_axi_arvalid & s_axi_arready;
            tk = s_axi_rvalid & s_axi_rready;
            v = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge core_clk);
            if (ta)
                s_axi_arvalid <= 1'b0;
            if (tk)
                s_axi_rready <= 1'b0;
        end
        chk(nm, v, x);
    endtask
    // **********************************
    // Clock, timeout and sequence
    // **********************************
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_fail++;
            end_sim();
        end
    end
    initial
    begin
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        chk("oe", pin_oe, 0);
        chk("pullup", pin_pullup, 0);
        rchk("latch", `OFS_LATCH, 0);
        rchk("dir", `OFS_DIRECTION, 0);
        rchk("unmapped", 8'h20, 0);
        chk("rresp", r, `RESP_SLVERR);
        wr(8'h20, 32'h000000FF);
        chk("bresp", r, `RESP_SLVERR);
        wr(8'h06, 32'h000000FF);
        chk("bresp", r, `RESP_SLVERR);
        rchk("unaligned", 8'h06, 0);
        chk("rresp", r, `RESP_SLVERR);
        for (int i = 0; i < 8; i++)
        begin
            d = rnd();
            l = rnd();
            t = rnd();
            e = rnd();
            wr(`OFS_DIRECTION, 32'h00000000);
            wr(`OFS_LATCH, 32'h00000000);
            wr(`OFS_LATCH, {24'h000000, l});
            wr(`OFS_DIRECTION, {24'h000000, d});
            wr(`OFS_CONTROL, {31'h0, i[0]});
            chk("pullup", pin_pullup, ~d & l & ~{8{i[0]}});
            chk("oe", pin_oe, d);
            chk("out", pin_out, l);
            rchk("ctrl", `OFS_CONTROL, i[0]);
            ext_val <= e;
            rchk("input", `OFS_INPUT, exp_in(d, l, e));
            wr(`OFS_INPUT, {24'h000000, t});
            chk("toggle", pin_out, l ^ t);
            rchk("readback", `OFS_INPUT, exp_in(d, l ^ t, e));
        end
        ext_val <= 8'hFF;
        wr(`OFS_DIRECTION, 32'h00000000);
        wr(`OFS_LATCH, 32'h00000000);
        wr(`OFS_CONTROL, 32'h00000000);
        ext_en <= 8'h00;
        wr(`OFS_LATCH, 32'h000000FF);
        rchk("pulled", `OFS_INPUT, 32'h000000FF);
        ext_en <= 8'hFF;
        wr(`OFS_LATCH, 32'h00000000);
        s_axi_wstrb <= 4'hE;
        wr(`OFS_LATCH, 32'h000000FF);
        s_axi_wstrb <= 4'hF;
        rchk("strobe", `OFS_LATCH, 0);
        wr(`OFS_IRQ_ENABLE, 32'h0000000F);
        wr(`OFS_SENSE, 32'h000000FF);
        wr(`OFS_MASK, 32'h000000FF);
        rchk("sense", `OFS_SENSE, 32'h000000FF);
        wr(`OFS_STATUS, 32'h000000FF);
        rchk("status", `OFS_STATUS, 0);
        chk("irq", irq, 0);
        sleep_clamp <= 1'b1;
        repeat (4) @(posedge core_clk);
        rchk("clamped", `OFS_INPUT, 32'h0000000F);
        rchk("ctrl", `OFS_CONTROL, 32'h00000002);
        wr(`OFS_STATUS, 32'h000000FF);
        rchk("status", `OFS_STATUS, 0);
        sleep_clamp <= 1'b0;
        repeat (4) @(posedge core_clk);
        rchk("wake", `OFS_STATUS, 32'h000000F0);
        chk("irq", irq, 1);
        wr(`OFS_MASK, 32'h00000000);
        chk("irq", irq, 0);
        wr(`OFS_MASK, 32'h000000FF);
        wr(`OFS_STATUS, 32'h000000F0);
        chk("irq", irq, 0);
        end_sim();
    end
endmodule // tb
